// ---- adc_offset_gain_correction.sv ----
// Two-channel offset and gain correction datapath with its trim registers
//
// Functional notes
// - With offset enabled, add the channel offset trim to the raw code.
// - Offset trim is 24-bit two's complement, added as a signed value.
// - Disabled corrections ignore stored trims, which stay intact and read back.
// - Gain trim is 24-bit signed, spanning -1x to just under +1x.
// - With gain enabled, multiply the code by one plus the gain trim.
// - Gain multiplication acts on the offset-corrected code, never before it.
// - One gain trim step changes the multiplier by two to the minus 23.
// - An 8-bit read/write reference temperature-coefficient trim register exists.
// - That trim register resets to 0x42.
// - One offset enable covers both channels and adds no delay.
// - One gain enable covers both channels and delays data and ready 24 clocks.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adc_offset_gain_correction
	import adc_corr_pkg::*;
#(
	parameter int DATA_W = CODE_WIDTH,
	parameter int GAIN_DELAY = GAIN_DELAY_CYCLES
) (
	// Clock, reset and clock enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// Avalon-MM slave, word addressed in bytes
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Raw codes from the decimation filters
	input wire logic [DATA_W-1:0] ch0Raw,
	input wire logic [DATA_W-1:0] ch1Raw,
	input wire logic rawValid,
	// Corrected codes towards the output path
	output logic [DATA_W-1:0] ch0Code,
	output logic [DATA_W-1:0] ch1Code,
	output logic codeValid,
	// Trim value handed to the reference block
	output logic [7:0] tempcoTrim
);
	typedef struct packed {
		bus_state_t bus;
		logic [31:0] rdata;
		logic [DATA_W-1:0] ch0Off;
		logic [DATA_W-1:0] ch0Gain;
		logic [DATA_W-1:0] ch1Off;
		logic [DATA_W-1:0] ch1Gain;
		logic [7:0] tempco;
		logic offsetEn;
		logic gainEn;
		logic [DATA_W-1:0] ch0Out;
		logic [DATA_W-1:0] ch1Out;
		logic valid;
	} top_state_t;
	top_state_t state_ff;
	top_state_t nxt_state;
	localparam int DW = 2 * DATA_W + 1;

	logic [DATA_W-1:0] ch0OffCode;
	logic [DATA_W-1:0] ch1OffCode;
	logic [DATA_W-1:0] ch0GainCode;
	logic [DATA_W-1:0] ch1GainCode;
	logic [DW-1:0] delayIn;
	logic [DW-1:0] delayOut;
	logic [7:0] index;
	logic [31:0] rdMux;

	// Trims are fixed at the code width; the latency check below needs a short plain delay
	if (DATA_W != CODE_WIDTH) begin : g_bad_width
		$error("DATA_W must equal the trim width");
	end
	if (GAIN_DELAY < 1 || GAIN_DELAY > 299) begin : g_bad_delay
		$error("GAIN_DELAY must lie between 1 and 299");
	end

	sat_offset_gain #(
		.W(DATA_W),
		.FRAC(GAIN_FRAC_BITS)
	) u_ch0 (
		.rawCode(ch0Raw),
		.offsetTrim(state_ff.ch0Off),
		.gainTrim(state_ff.ch0Gain),
		.offsetEn(state_ff.offsetEn),
		.gainEn(state_ff.gainEn),
		.offsetCode(ch0OffCode),
		.gainCode(ch0GainCode)
	);
	sat_offset_gain #(
		.W(DATA_W),
		.FRAC(GAIN_FRAC_BITS)
	) u_ch1 (
		.rawCode(ch1Raw),
		.offsetTrim(state_ff.ch1Off),
		.gainTrim(state_ff.ch1Gain),
		.offsetEn(state_ff.offsetEn),
		.gainEn(state_ff.gainEn),
		.offsetCode(ch1OffCode),
		.gainCode(ch1GainCode)
	);

	// Gain path pays a fixed latency; strobe travels with its data
	assign delayIn = {rawValid, ch1GainCode, ch0GainCode};
	delay_line #(
		.W(DW),
		.DEPTH(GAIN_DELAY)
	) u_delay (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.din(delayIn),
		.dout(delayOut)
	);

	assign index = address[9:2];

	always_comb begin
		rdMux = 32'h00000000;
		case (index)
			IDX_CH0_OFFSET: rdMux = {8'h00, state_ff.ch0Off};
			IDX_CH0_GAIN: rdMux = {8'h00, state_ff.ch0Gain};
			IDX_CH1_OFFSET: rdMux = {8'h00, state_ff.ch1Off};
			IDX_CH1_GAIN: rdMux = {8'h00, state_ff.ch1Gain};
			IDX_TEMPCO: rdMux = {24'h000000, state_ff.tempco};
			IDX_CONTROL: rdMux = {30'h00000000, state_ff.gainEn, state_ff.offsetEn};
			IDX_STATUS: rdMux = {31'h00000000, state_ff.valid};
			default: rdMux = 32'h00000000;
		endcase
	end

	function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [23:0] r;
		r = old;
		for (int b = 0; b < 3; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction : merge24

	always_comb begin
		nxt_state = state_ff;
		case (state_ff.bus)
			BUS_IDLE: begin
				// One wait cycle lets read data come from a flop
				if (read || write) begin
					nxt_state.bus = BUS_ANSWER;
					nxt_state.rdata = rdMux;
				end
			end
			BUS_ANSWER: begin
				nxt_state.bus = BUS_IDLE;
				if (write) begin
					case (index)
						IDX_CH0_OFFSET: nxt_state.ch0Off = merge24(state_ff.ch0Off, writedata, byteenable);
						IDX_CH0_GAIN: nxt_state.ch0Gain = merge24(state_ff.ch0Gain, writedata, byteenable);
						IDX_CH1_OFFSET: nxt_state.ch1Off = merge24(state_ff.ch1Off, writedata, byteenable);
						IDX_CH1_GAIN: nxt_state.ch1Gain = merge24(state_ff.ch1Gain, writedata, byteenable);
						IDX_TEMPCO: begin
							if (byteenable[0]) nxt_state.tempco = writedata[7:0];
						end
						IDX_CONTROL: begin
							if (byteenable[0]) begin
								nxt_state.offsetEn = writedata[CTRL_OFFSET_EN_BIT];
								nxt_state.gainEn = writedata[CTRL_GAIN_EN_BIT];
							end
						end
						default: begin
						end
					endcase
				end
			end
			default: nxt_state.bus = BUS_IDLE;
		endcase
		// Output stage: gain mode takes the delayed path, offset mode none
		if (state_ff.gainEn) begin
			nxt_state.ch0Out = delayOut[DATA_W-1:0];
			nxt_state.ch1Out = delayOut[2*DATA_W-1:DATA_W];
			nxt_state.valid = delayOut[DW-1];
		end else begin
			nxt_state.ch0Out = ch0OffCode;
			nxt_state.ch1Out = ch1OffCode;
			nxt_state.valid = rawValid;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff.bus <= BUS_IDLE;
			state_ff.rdata <= 32'h00000000;
			state_ff.ch0Off <= OFFSET_RESET;
			state_ff.ch0Gain <= GAIN_RESET;
			state_ff.ch1Off <= OFFSET_RESET;
			state_ff.ch1Gain <= GAIN_RESET;
			state_ff.tempco <= TEMPCO_RESET;
			state_ff.offsetEn <= CONTROL_RESET[CTRL_OFFSET_EN_BIT];
			state_ff.gainEn <= CONTROL_RESET[CTRL_GAIN_EN_BIT];
			state_ff.ch0Out <= '0;
			state_ff.ch1Out <= '0;
			state_ff.valid <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	assign waitrequest = (read || write) && (state_ff.bus != BUS_ANSWER);
	assign readdata = state_ff.rdata;
	assign ch0Code = state_ff.ch0Out;
	assign ch1Code = state_ff.ch1Out;
	assign codeValid = state_ff.valid;
	assign tempcoTrim = state_ff.tempco;


	// Register side
	a_tempco_reset: assert property (@(posedge clk)
		$rose(rstn) |-> tempcoTrim == TEMPCO_RESET)
		else $error("tempco trim not at reset value");
	a_tempco_read: assert property (@(posedge clk) disable iff (!rstn)
		read && state_ff.bus == BUS_ANSWER && index == IDX_TEMPCO
		|-> readdata == {24'h000000, tempcoTrim})
		else $error("tempco trim read back wrong");
	a_tempco_write: assert property (@(posedge clk) disable iff (!rstn)
		ce && write && state_ff.bus == BUS_ANSWER && index == IDX_TEMPCO && byteenable[0]
		|=> tempcoTrim == $past(writedata[7:0]))
		else $error("tempco trim write lost");
	// One wait state keeps read data on a flop instead of a long mux path
	a_wait_one: assert property (@(posedge clk) disable iff (!rstn)
		ce && (read || write) && state_ff.bus == BUS_IDLE |=> state_ff.bus == BUS_ANSWER)
		else $error("bus did not answer after one wait");
	a_trim_keep: assert property (@(posedge clk) disable iff (!rstn)
		!(write && state_ff.bus == BUS_ANSWER) |=> $stable(state_ff.ch0Off))
		else $error("trim changed without write");
	a_ctrl_keeps_trim: assert property (@(posedge clk) disable iff (!rstn)
		ce && write && state_ff.bus == BUS_ANSWER && index == IDX_CONTROL
		|=> $stable(state_ff.ch1Off) && $stable(state_ff.ch1Gain))
		else $error("enable write altered a trim");

	// Offset step
	a_offset_nodelay: assert property (@(posedge clk) disable iff (!rstn)
		ce && !state_ff.gainEn && state_ff.offsetEn && rawValid |=> codeValid)
		else $error("offset path added delay");
	a_offset_sum: assert property (@(posedge clk) disable iff (!rstn)
		ce && !state_ff.gainEn && state_ff.offsetEn && ch0Raw == 24'h000000
		|=> ch0Code == $past(state_ff.ch0Off))
		else $error("offset not added");
	a_bypass_raw: assert property (@(posedge clk) disable iff (!rstn)
		ce && !state_ff.gainEn && !state_ff.offsetEn |=> ch1Code == $past(ch1Raw))
		else $error("disabled path altered code");
	a_offset_bypass: assert property (@(posedge clk) disable iff (!rstn)
		!state_ff.offsetEn |-> ch1OffCode == ch1Raw)
		else $error("disabled offset altered code");
	// A non-negative trim can only push full scale further up
	a_offset_sat: assert property (@(posedge clk) disable iff (!rstn)
		ce && !state_ff.gainEn && state_ff.offsetEn && ch0Raw == 24'h7FFFFF
		&& !state_ff.ch0Off[23] |=> ch0Code == 24'h7FFFFF)
		else $error("offset overflow wrapped");

	// Gain step
	a_unity_gain: assert property (@(posedge clk) disable iff (!rstn)
		ce && state_ff.gainEn && !state_ff.offsetEn && state_ff.ch0Gain == 24'h000000
		|-> ch0GainCode == ch0Raw)
		else $error("zero trim not unity gain");
	a_gain_bypass: assert property (@(posedge clk) disable iff (!rstn)
		!state_ff.gainEn |-> ch0GainCode == ch0OffCode)
		else $error("disabled gain altered code");
	// Half-scale input moves by half the trim when one trim step weighs 2^-23
	a_gain_lsb: assert property (@(posedge clk) disable iff (!rstn)
		state_ff.gainEn && !state_ff.offsetEn && ch1Raw == 24'h400000
		|-> ch1GainCode == 24'h400000 + 24'($signed(state_ff.ch1Gain) >>> 1))
		else $error("gain lsb step wrong");
	a_gain_after_off: assert property (@(posedge clk) disable iff (!rstn)
		state_ff.gainEn && state_ff.offsetEn && state_ff.ch1Gain == 24'h800000
		|-> ch1GainCode == 24'h000000)
		else $error("zero factor nonzero result");
	// A non-negative trim can only grow a full-scale code, so it must pin at the top
	a_gain_sat: assert property (@(posedge clk) disable iff (!rstn)
		state_ff.gainEn && !state_ff.offsetEn && ch0Raw == 24'h7FFFFF
		&& !state_ff.ch0Gain[23] |-> ch0GainCode == 24'h7FFFFF)
		else $error("gain overflow wrapped");

	// A strobe taken with gain on leaves the line after the fixed latency, then the output flop
	sequence s_strobe_in;
		ce && state_ff.gainEn && rawValid;
	endsequence
	sequence s_strobe_tap;
		##GAIN_DELAY delayOut[DW-1];
	endsequence
	sequence s_strobe_out;
		codeValid;
	endsequence
	a_gain_delay: assert property (@(posedge clk)
		disable iff (!rstn || !ce || !state_ff.gainEn)
		s_strobe_in |-> s_strobe_tap ##1 s_strobe_out)
		else $error("gain path latency wrong");
endmodule : adc_offset_gain_correction
`default_nettype wire

// ---- adc_corr_pkg.sv ----
// Package with register map, reset values and timing counts of the correction datapath
package adc_corr_pkg;
	// Printed offsets are register indices; byte address is four times the index
	localparam logic [7:0] IDX_CH0_OFFSET = 8'h0E;
	localparam logic [7:0] IDX_CH0_GAIN = 8'h11;
	localparam logic [7:0] IDX_CH1_OFFSET = 8'h14;
	localparam logic [7:0] IDX_CH1_GAIN = 8'h17;
	localparam logic [7:0] IDX_TEMPCO = 8'h1A;
	localparam logic [7:0] IDX_CONTROL = 8'h20;
	localparam logic [7:0] IDX_STATUS = 8'h21;
	localparam int CTRL_OFFSET_EN_BIT = 0;
	localparam int CTRL_GAIN_EN_BIT = 1;
	localparam logic [23:0] OFFSET_RESET = 24'h000000;
	localparam logic [23:0] GAIN_RESET = 24'h000000;
	localparam logic [7:0] TEMPCO_RESET = 8'h42;
	localparam logic [1:0] CONTROL_RESET = 2'h0;
	localparam int GAIN_FRAC_BITS = 23;
	localparam int GAIN_DELAY_CYCLES = 24;
	localparam int CODE_WIDTH = 24;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ANSWER = 2'b01
	} bus_state_t;
endpackage : adc_corr_pkg

// ---- sat_offset_gain.sv ----
// One channel of offset addition, gain multiplication and saturation
`timescale 1ns/1ps
`default_nettype none
module sat_offset_gain
	import adc_corr_pkg::*;
#(
	parameter int W = 24,
	parameter int FRAC = 23
) (
	// Operands
	input wire logic [W-1:0] rawCode,
	input wire logic [W-1:0] offsetTrim,
	input wire logic [W-1:0] gainTrim,
	input wire logic offsetEn,
	input wire logic gainEn,
	// Results
	output logic [W-1:0] offsetCode,
	output logic [W-1:0] gainCode
);
	localparam logic signed [W+1:0] MAXV = (W+2)'((1 <<< (W-1)) - 1);
	localparam logic signed [W+1:0] MINV = -(W+2)'(1 <<< (W-1));
	localparam logic signed [2*W+2:0] MAXP = (2*W+3)'(MAXV);
	localparam logic signed [2*W+2:0] MINP = (2*W+3)'(MINV);
	logic signed [W+1:0] sum;
	logic signed [W+1:0] factor;
	logic signed [2*W+2:0] prod;
	logic signed [2*W+2:0] scaled;
	// The fraction must leave at least one integer bit for the unity term
	if (W < 2 || FRAC >= W) begin : g_bad_widths
		$error("sat_offset_gain: bad widths");
	end
	always_comb begin
		sum = (W+2)'(signed'(rawCode));
		if (offsetEn) begin
			sum = sum + (W+2)'(signed'(offsetTrim));
		end
		if (sum > MAXV) begin
			offsetCode = MAXV[W-1:0];
		end else if (sum < MINV) begin
			offsetCode = MINV[W-1:0];
		end else begin
			offsetCode = sum[W-1:0];
		end
		// Factor is 1 + trim with FRAC fractional bits, range 0 .. nearly 2
		factor = (W+2)'(signed'(gainTrim)) + (W+2)'(1 <<< FRAC);
		prod = (2*W+3)'(signed'(offsetCode)) * (2*W+3)'(factor);
		scaled = prod >>> FRAC;
		if (!gainEn) begin
			gainCode = offsetCode;
		end else if (scaled > MAXP) begin
			gainCode = MAXP[W-1:0];
		end else if (scaled < MINP) begin
			gainCode = MINP[W-1:0];
		end else begin
			gainCode = scaled[W-1:0];
		end
	end
endmodule : sat_offset_gain
`default_nettype wire

// ---- delay_line.sv ----
// Fixed-length delay line for code words with their ready strobe
`timescale 1ns/1ps
`default_nettype none
module delay_line #(
	parameter int W = 49,
	parameter int DEPTH = 24
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] stage;
	} dl_state_t;
	dl_state_t state_ff;
	dl_state_t nxt_state;
	if (DEPTH < 1 || W < 1) begin : g_bad_size
		$error("delay_line: bad size");
	end
	always_comb begin
		nxt_state = state_ff;
		nxt_state.stage[0] = din;
		for (int i = 1; i < DEPTH; i++) begin
			nxt_state.stage[i] = state_ff.stage[i-1];
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= '0;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end
	assign dout = state_ff.stage[DEPTH-1];
endmodule : delay_line
`default_nettype wire

// ---- decim_source.sv ----
// Model of the two decimation filters feeding raw codes with a ready pulse
`timescale 1ns/1ps
`default_nettype none
module decim_source (
	// Clock, reset and run control
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	// Raw codes towards the datapath
	output logic [23:0] ch0Raw,
	output logic [23:0] ch1Raw,
	output logic rawValid
);
	logic [23:0] corner [6] = '{24'h7FFFFF, 24'h800000, 24'h000000, 24'hFFFFFF, 24'h400000,
		24'hC00000};
	int seed = 69;
	int gap = 0;
	int n = 0;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ch0Raw <= 24'h000000;
			ch1Raw <= 24'h000000;
			rawValid <= 1'b0;
		end else begin
			rawValid <= 1'b0;
			// Words are only meaningful with the pulse, so scramble them in between
			ch0Raw <= ~ch0Raw;
			ch1Raw <= ~ch1Raw;
			if (!run) n <= 0;
			if (gap > 0) begin
				gap <= gap - 1;
			end else if (run) begin
				rawValid <= 1'b1;
				ch0Raw <= (n < 6) ? corner[n] : 24'($random(seed));
				ch1Raw <= (n < 6) ? corner[5 - n] : 24'($random(seed));
				n <= n + 1;
				// A gap of zero gives back-to-back samples
				gap <= $unsigned($random(seed)) % 4;
			end
		end
	end
endmodule : decim_source
`default_nettype wire

// ---- adc_offset_gain_correction_tb.sv ----
// Self-checking bench for the two-channel offset and gain correction datapath
`timescale 1ns/1ps
`default_nettype none
module adc_offset_gain_correction_tb;
	import adc_corr_pkg::*;
	localparam int GD = GAIN_DELAY_CYCLES;
	logic clk = 0, rstn = 0, read = 0, write = 0, run = 0, watch = 0;
	logic rawValid, codeValid, waitrequest;
	logic [9:0] address = 10'h000;
	logic [31:0] writedata = 32'h00000000, readdata, rd;
	logic [23:0] ch0Raw, ch1Raw, ch0Code, ch1Code;
	logic [23:0] off [2], gain [2];
	logic [7:0] tempcoTrim;
	logic [1:0] ctl = 2'h0;
	logic [23:0] e0q[$], e1q[$];
	int tq[$];
	int fails = 0, totalChecks = 0, cyc = 0, seed = 69, got = 0;
	initial forever #12.5 clk = ~clk;
	adc_offset_gain_correction #(.GAIN_DELAY(GD)) u_dut (.clk(clk), .rstn(rstn), .ce(1'b1),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest), .ch0Raw(ch0Raw),
		.ch1Raw(ch1Raw), .rawValid(rawValid), .ch0Code(ch0Code), .ch1Code(ch1Code),
		.codeValid(codeValid), .tempcoTrim(tempcoTrim));
	decim_source u_src (.clk(clk), .rstn(rstn), .run(run), .ch0Raw(ch0Raw), .ch1Raw(ch1Raw),
		.rawValid(rawValid));
	task tally_and_finish;
		if (fails == 0 && totalChecks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge clk);
		address <= {idx, 2'b00};
		writedata <= wd;
		write <= wr;
		read <= !wr;
		// No fixed wait is assumed; only the watchdog ends a hung access
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task rdchk(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h00000000);
		check(rd, exp);
	endtask : rdchk
	function automatic logic [23:0] sat(logic signed [50:0] v);
		if (v > 51'sd8388607) return 24'h7FFFFF;
		if (v < -51'sd8388608) return 24'h800000;
		return v[23:0];
	endfunction : sat
	function automatic logic [23:0] model(logic [23:0] raw, logic [23:0] o, logic [23:0] g);
		logic signed [50:0] s, f;
		s = $signed(raw);
		if (ctl[CTRL_OFFSET_EN_BIT]) s = $signed(sat(s + $signed(o)));
		f = (51'sd1 <<< GAIN_FRAC_BITS) + $signed(g);
		if (!ctl[CTRL_GAIN_EN_BIT]) return s[23:0];
		return sat((s * f) >>> GAIN_FRAC_BITS);
	endfunction : model
	always @(posedge clk) begin
		cyc++;
		if (codeValid === 1'b1 && watch) begin
			if (tq.size() == 0) check(32'h1, 32'h0);
			else begin
				check(ch0Code, e0q.pop_front());
				check(ch1Code, e1q.pop_front());
				check(cyc - tq.pop_front(), ctl[CTRL_GAIN_EN_BIT] ? GD + 1 : 1);
				got++;
			end
		end
		if (rawValid === 1'b1) begin
			e0q.push_back(model(ch0Raw, off[0], gain[0]));
			e1q.push_back(model(ch1Raw, off[1], gain[1]));
			tq.push_back(cyc);
		end
	end
	initial begin
		repeat (30000) @(posedge clk);
		fails++;
		tally_and_finish;
	end
	initial begin
		off = '{24'h0, 24'h0};
		gain = '{24'h0, 24'h0};
		repeat (12) @(posedge clk);
		check(tempcoTrim, TEMPCO_RESET);
		rstn <= 1'b1;
		rdchk(IDX_CH0_OFFSET, OFFSET_RESET);
		rdchk(IDX_CH0_GAIN, GAIN_RESET);
		rdchk(IDX_CH1_OFFSET, OFFSET_RESET);
		rdchk(IDX_CH1_GAIN, GAIN_RESET);
		rdchk(IDX_TEMPCO, TEMPCO_RESET);
		rdchk(IDX_CONTROL, 32'h0);
		// Deliberate calibration write of the reference trim
		bus(1'b1, IDX_TEMPCO, 32'hFFFFFF5A);
		rdchk(IDX_TEMPCO, 32'h5A);
		check(tempcoTrim, 8'h5A);
		bus(1'b1, 8'hFF, 32'hFFFFFFFF);
		rdchk(8'hFF, 32'h0);
		for (int set = 0; set < 3; set++) begin
			for (int c = 0; c < 2; c++) begin
				off[c] = (set == 1) ? (c ? 24'h800000 : 24'h7FFFFF) : 24'($random(seed));
				gain[c] = (set == 1) ? (c ? 24'h800000 : 24'h7FFFFF) : 24'($random(seed));
				// Last set runs at exact unity gain with random offsets
				if (set == 2) gain[c] = GAIN_RESET;
				bus(1'b1, c ? IDX_CH1_OFFSET : IDX_CH0_OFFSET, {8'hA5, off[c]});
				bus(1'b1, c ? IDX_CH1_GAIN : IDX_CH0_GAIN, {8'h5A, gain[c]});
			end
			for (int m = 0; m < 4; m++) begin
				bus(1'b1, IDX_CONTROL, m);
				ctl = 2'(m);
				// Let stale pulses of the other path drain before watching
				repeat (GD + 4) @(posedge clk);
				watch <= 1'b1;
				got = 0;
				run <= 1'b1;
				for (int k = 0; k < 400 && got < 12; k++) @(posedge clk);
				run <= 1'b0;
				repeat (GD + 8) @(posedge clk);
				check(tq.size(), 0);
				watch <= 1'b0;
				rdchk(IDX_CH0_OFFSET, {8'h00, off[0]});
				rdchk(IDX_CH0_GAIN, {8'h00, gain[0]});
				rdchk(IDX_CH1_OFFSET, {8'h00, off[1]});
				rdchk(IDX_CH1_GAIN, {8'h00, gain[1]});
			end
		end
		tally_and_finish;
	end
endmodule : adc_offset_gain_correction_tb
`default_nettype wire
